// ===== hdl/exec_alu.sv
// combinational byte and word arithmetic with status flag generation
`timescale 1ns/1ps
module exec_alu
	import exec_pkg::*;
(
	// operation and operands
	input wire exec_pkg::op_t op,
	input wire logic [7:0] a,
	input wire logic [7:0] b,
	input wire logic [7:0] flags_in,
	// results
	output logic [15:0] result,
	output logic [7:0] flags_out,
	output logic writes
);
	logic [8:0] sum9;
	logic [4:0] sum5;
	logic [16:0] w17;
	logic [7:0] r8;
	logic cin;
	logic is_sub;
	// carry or borrow in for the chained forms
	assign cin = (op == OP_ADC || op == OP_DIFF_BORROW ||
		op == OP_CONST_DIFF_BORROW || op == OP_CMP_CARRY) ?
		flags_in[FLAG_C] : 1'b0;

	always_comb begin
		result = 16'h0000;
		flags_out = flags_in;
		writes = 1'b0;
		sum9 = 9'h000;
		sum5 = 5'h00;
		w17 = 17'h00000;
		r8 = 8'h00;
		is_sub = 1'b0;
		unique case (op)
			OP_ADD, OP_ADC: begin
				sum9 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
				sum5 = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
				r8 = sum9[7:0];
				flags_out[FLAG_C] = sum9[8];
				flags_out[FLAG_H] = sum5[4];
				flags_out[FLAG_V] = (a[7] == b[7]) && (r8[7] != a[7]);
				writes = 1'b1;
			end
			// subtract, negate and compare share one borrow chain
			OP_SUB, OP_DIFF_CONST, OP_DIFF_BORROW, OP_CONST_DIFF_BORROW,
			OP_TWOS, OP_CMP, OP_CMP_CARRY, OP_CMP_CONST: begin
				is_sub = 1'b1;
				sum9 = {1'b0, a} - {1'b0, b} - {8'h00, cin};
				sum5 = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
				r8 = sum9[7:0];
				flags_out[FLAG_C] = sum9[8];
				flags_out[FLAG_H] = sum5[4];
				flags_out[FLAG_V] = (a[7] != b[7]) && (r8[7] != a[7]);
				writes = !(op == OP_CMP || op == OP_CMP_CARRY ||
					op == OP_CMP_CONST);
			end
			OP_AND, OP_AND_CONST, OP_CHECK: begin
				r8 = a & b;
				flags_out[FLAG_V] = 1'b0;
				writes = (op != OP_CHECK);
			end
			OP_OR, OP_OR_CONST, OP_SET_MASK: begin
				r8 = a | b;
				flags_out[FLAG_V] = 1'b0;
				writes = 1'b1;
			end
			OP_XOR, OP_CLEAR: begin
				r8 = a ^ b;
				flags_out[FLAG_V] = 1'b0;
				writes = 1'b1;
			end
			OP_INVERT: begin
				r8 = ONES - a;
				flags_out[FLAG_C] = 1'b1;
				flags_out[FLAG_V] = 1'b0;
				writes = 1'b1;
			end
			OP_SET_ALL: begin // no flag changes
				r8 = ONES;
				writes = 1'b1;
			end
			OP_WORD_ADD, OP_WORD_SUB: begin // b:a is the pair, b the high byte
				w17 = (op == OP_WORD_ADD) ?
					({1'b0, b, a} + {11'h000, flags_in[5:0]}) :
					({1'b0, b, a} - {11'h000, flags_in[5:0]});
				result = w17[15:0];
				flags_out[FLAG_C] = w17[16];
				flags_out[FLAG_Z] = (w17[15:0] == 16'h0000);
				flags_out[FLAG_N] = w17[15];
				flags_out[FLAG_V] = (op == OP_WORD_ADD) ?
					(!b[7] && w17[15]) : (b[7] && !w17[15]);
				flags_out[FLAG_S] = w17[15] ^ flags_out[FLAG_V];
				writes = 1'b1;
			end
			default: begin
				writes = 1'b0;
			end
		endcase
		// byte ops except OP_SET_ALL share zero and negative, word ops set their own
		if (op != OP_WORD_ADD && op != OP_WORD_SUB && op != OP_SET_ALL &&
			(writes || is_sub || op == OP_CHECK)) begin
			result = {8'h00, r8};
			flags_out[FLAG_Z] = (r8 == ZERO8);
			flags_out[FLAG_N] = r8[7];
			flags_out[FLAG_S] = r8[7] ^ flags_out[FLAG_V];
		end else if (op == OP_SET_ALL) begin
			result = {8'h00, r8};
		end
	end
endmodule

// ===== hdl/exec_core.sv
// execute stage for arithmetic, logic, branch and io bit instructions
`timescale 1ns/1ps
//
// Overview of operation
// - io bit set/clear only for 0x00..0x1F
// - skip on io bit high or low, only for 0x00..0x1F
// - io bit set/clear touches only that bit
// - add with optional carry, six flags, 1 cycle
// - word add/sub immediate, 2 cycles
// - subtract with optional borrow, 1 cycle
// - and, or, xor update Z N V S
// - set mask bits ors constant, 1 cycle
// - check ands register with itself
// - pointer jump loads pc from Z, 2 cycles
// - pointer call pushes return, 3 cycles
// - compare skip equal skips next instruction
// - compares set flags without storing result
module exec_core
	import exec_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// instruction from fetch, same clock
	input wire logic instr_valid,
	input wire exec_pkg::op_t instr_op,
	input wire logic [7:0] opnd_a,
	input wire logic [7:0] opnd_b,
	input wire logic [7:0] opnd_k,
	input wire logic [2:0] bit_sel,
	input wire logic [7:0] io_addr,
	input wire logic [11:0] rel_offset,
	input wire logic [15:0] z_ptr,
	input wire logic next_is_long,
	// io register read data, same clock
	input wire logic [7:0] io_rdata,
	// execution status
	output logic busy,
	output logic [11:0] pc,
	output logic [7:0] sreg,
	// register file write back
	output logic rf_we,
	output logic rf_wide,
	output logic [15:0] rf_wdata,
	// io bit write strobe, single bit only
	output logic io_bit_we,
	output logic [7:0] io_bit_addr,
	output logic [2:0] io_bit_num,
	output logic io_bit_val
);
	logic [2:0] wait_q, wait_d;
	logic busy_q; // registered twin of a nonzero stall count
	logic [11:0] pc_q, pc_d;
	logic [7:0] sreg_q;
	logic [7:0] sp_q;
	logic [11:0] stack_mem [STACK_DEPTH];
	logic rf_we_q, rf_wide_q, io_we_q, io_val_q;
	logic [15:0] rf_wdata_q;
	logic [7:0] io_addr_q;
	logic [2:0] io_num_q;
	logic [15:0] alu_res;
	logic [7:0] alu_flags, alu_b;
	logic alu_writes;
	logic word_op; // word add or subtract immediate on a pair
	logic [7:0] alu_a_in, alu_b_in, alu_f_in; // alu operand selection
	logic [7:0] new_flags; // flags to load into the status register
	logic take, io_ok, skip_cond, is_skip;
	logic [11:0] pc_next, skip_pc, pop_pc;
	logic [2:0] cycles;

	// word forms are decoded in several places, so decode them once
	function automatic logic is_word_op(input op_t o);
		return (o == OP_WORD_ADD) || (o == OP_WORD_SUB);
	endfunction
	assign word_op = is_word_op(instr_op);

	// constant forms use K, self forms reuse the first operand
	assign alu_b = (instr_op == OP_DIFF_CONST ||
		instr_op == OP_CONST_DIFF_BORROW || instr_op == OP_AND_CONST ||
		instr_op == OP_OR_CONST || instr_op == OP_SET_MASK ||
		instr_op == OP_CMP_CONST) ? opnd_k :
		(instr_op == OP_CHECK || instr_op == OP_CLEAR) ? opnd_a :
		opnd_b;
	// negation is zero minus the register
	assign alu_a_in = (instr_op == OP_TWOS) ? ZERO8 : opnd_a;
	assign alu_b_in = (instr_op == OP_TWOS) ? opnd_a : alu_b;
	// word ops pass the 6-bit immediate through flags_in
	assign alu_f_in = word_op ? {2'b00, opnd_k[5:0]} : sreg_q;

	exec_alu exec_alu_inst (
		.op(instr_op),
		.a(alu_a_in),
		.b(alu_b_in),
		.flags_in(alu_f_in),
		.result(alu_res),
		.flags_out(alu_flags),
		.writes(alu_writes)
	);

	// after a word op restore the real upper flags and half carry
	assign new_flags = word_op ?
		{sreg_q[7:6], sreg_q[FLAG_H], alu_flags[4:0]} : alu_flags;

	// new instructions accepted only while idle
	assign take = instr_valid && (wait_q == 3'd0);
	// io bit ops outside the low range are ignored
	assign io_ok = (io_addr <= IO_BIT_MAX);
	assign pc_next = pc_q + 12'd1;
	// skipping a long instruction steps three words, else two
	assign skip_pc = next_is_long ? pc_q + 12'd3 : pc_q + 12'd2;
	assign pop_pc = stack_mem[4'(sp_q + 8'd1)];
	assign skip_cond = (instr_op == OP_CMP_SKIP) ? (opnd_a == opnd_b) :
		(instr_op == OP_SKIP_IO_HIGH) ? (io_ok && io_rdata[bit_sel]) :
		(io_ok && !io_rdata[bit_sel]);
	assign is_skip = instr_op == OP_CMP_SKIP ||
		instr_op == OP_SKIP_IO_HIGH || instr_op == OP_SKIP_IO_LOW;

	// cycle count and next pc for the accepted instruction
	always_comb begin
		cycles = {1'b0, CYC_ONE};
		pc_d = pc_next;
		unique case (instr_op)
			OP_WORD_ADD, OP_WORD_SUB: cycles = {1'b0, CYC_TWO};
			OP_IO_SET, OP_IO_CLEAR: cycles = {1'b0, CYC_TWO};
			OP_REL_JUMP: begin
				cycles = {1'b0, CYC_TWO};
				pc_d = pc_q + rel_offset + 12'd1;
			end
			OP_REL_CALL: begin
				cycles = {1'b0, CYC_THREE};
				pc_d = pc_q + rel_offset + 12'd1;
			end
			OP_PTR_JUMP: begin
				cycles = {1'b0, CYC_TWO};
				pc_d = z_ptr[11:0];
			end
			OP_PTR_CALL: begin
				cycles = {1'b0, CYC_THREE};
				pc_d = z_ptr[11:0];
			end
			OP_SUB_EXIT, OP_INT_EXIT: begin
				cycles = CYC_RET;
				pc_d = pop_pc;
			end
			OP_CMP_SKIP, OP_SKIP_IO_HIGH, OP_SKIP_IO_LOW: begin
				if (skip_cond) begin
					cycles = next_is_long ? {1'b0, CYC_THREE} :
						{1'b0, CYC_TWO};
					pc_d = skip_pc;
				end
			end
			default: begin
				cycles = {1'b0, CYC_ONE};
			end
		endcase
	end
	assign wait_d = take ? cycles - 3'd1 :
		(wait_q != 3'd0) ? wait_q - 3'd1 : 3'd0;

	// sequencing: pc, stall counter and the small return stack
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			pc_q <= PC_RESET;
			wait_q <= 3'd0;
			busy_q <= 1'b0;
			sp_q <= SP_RESET;
		end else begin
			wait_q <= wait_d;
			// registered so busy leaves the block straight from a flop
			busy_q <= (wait_d != 3'd0);
			if (take) begin
				pc_q <= pc_d;
				// calls push the return address
				if (instr_op == OP_REL_CALL || instr_op == OP_PTR_CALL) begin
					stack_mem[4'(sp_q)] <= pc_next;
					sp_q <= sp_q - 8'd1;
				end else if (instr_op == OP_SUB_EXIT ||
					instr_op == OP_INT_EXIT) begin
					sp_q <= sp_q + 8'd1;
				end
			end
		end
	end

	// status register; flags unchanged by jumps and calls
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			sreg_q <= SREG_RESET;
		end else if (take) begin
			if (instr_op == OP_INT_EXIT) begin
				sreg_q[FLAG_I] <= 1'b1;
			end else if (!is_skip && instr_op != OP_SET_ALL) begin
				sreg_q <= new_flags;
			end
		end
	end

	// write back and single-bit io strobes, all registered
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			rf_we_q <= 1'b0;
			rf_wide_q <= 1'b0;
			rf_wdata_q <= 16'h0000;
			io_we_q <= 1'b0;
			io_addr_q <= 8'h00;
			io_num_q <= 3'd0;
			io_val_q <= 1'b0;
		end else begin
			rf_we_q <= take && alu_writes;
			rf_wide_q <= word_op;
			rf_wdata_q <= alu_res;
			// only the addressed bit is strobed, never a byte write
			io_we_q <= take && io_ok &&
				(instr_op == OP_IO_SET || instr_op == OP_IO_CLEAR);
			io_addr_q <= io_addr;
			io_num_q <= bit_sel;
			io_val_q <= instr_op == OP_IO_SET;
		end
	end

	assign busy = busy_q;
	assign pc = pc_q;
	assign sreg = sreg_q;
	assign rf_we = rf_we_q;
	assign rf_wide = rf_wide_q;
	assign rf_wdata = rf_wdata_q;
	assign io_bit_we = io_we_q;
	assign io_bit_addr = io_addr_q;
	assign io_bit_num = io_num_q;
	assign io_bit_val = io_val_q;

	// assertions; stall shapes after the taking edge
	sequence s_two;
		busy ##1 !busy;
	endsequence
	sequence s_three;
		busy ##1 busy ##1 !busy;
	endsequence
	sequence s_four;
		busy[*3] ##1 !busy;
	endsequence
	property p_io_range;
		@(posedge mclk) disable iff (!reset_n)
		io_bit_we |-> io_bit_addr <= IO_BIT_MAX;
	endproperty
	a_io_range: assert property (p_io_range)
		else $error("io bit out of range");
	property p_word_two;
		@(posedge mclk) disable iff (!reset_n)
		take && instr_op == OP_WORD_ADD |=> s_two;
	endproperty
	a_word_two: assert property (p_word_two)
		else $error("word op not 2 cycles");
	property p_ptr_jump;
		@(posedge mclk) disable iff (!reset_n)
		take && instr_op == OP_PTR_JUMP |=> pc == $past(z_ptr[11:0]);
	endproperty
	a_ptr_jump: assert property (p_ptr_jump)
		else $error("pointer jump pc");
	property p_ptr_call;
		@(posedge mclk) disable iff (!reset_n)
		take && instr_op == OP_PTR_CALL |=> s_three;
	endproperty
	a_ptr_call: assert property (p_ptr_call)
		else $error("pointer call timing");
	property p_ret_four;
		@(posedge mclk) disable iff (!reset_n)
		take && instr_op == OP_SUB_EXIT |=> s_four;
	endproperty
	a_ret_four: assert property (p_ret_four)
		else $error("return not 4 cycles");
	property p_cmp_nowrite;
		@(posedge mclk) disable iff (!reset_n)
		take && instr_op == OP_CMP |=> !rf_we;
	endproperty
	a_cmp_nowrite: assert property (p_cmp_nowrite)
		else $error("compare wrote");
	property p_add_one;
		@(posedge mclk) disable iff (!reset_n)
		take && instr_op == OP_ADD |=> rf_we && !busy;
	endproperty
	a_add_one: assert property (p_add_one)
		else $error("add timing");
	property p_skip;
		@(posedge mclk) disable iff (!reset_n)
		take && instr_op == OP_CMP_SKIP && opnd_a == opnd_b && !next_is_long
		|=> pc == $past(pc_q) + 12'd2;
	endproperty
	a_skip: assert property (p_skip)
		else $error("skip pc wrong");
	property p_interrupt_exit_i;
		@(posedge mclk) disable iff (!reset_n)
		take && instr_op == OP_INT_EXIT |=> sreg[FLAG_I];
	endproperty
	a_interrupt_exit_i: assert property (p_interrupt_exit_i)
		else $error("interrupt exit I");
endmodule

// ===== hdl/exec_pkg.sv
// shared constants and types for the arithmetic and branch execute slice
package exec_pkg;
	localparam int PC_W = 12;
	localparam logic [7:0] IO_BIT_MAX = 8'h1F;
	localparam logic [7:0] ONES = 8'hFF;
	localparam logic [7:0] ZERO8 = 8'h00;
	localparam logic [PC_W-1:0] PC_RESET = 12'h000;
	localparam logic [7:0] SP_RESET = 8'hFF;
	localparam int STACK_DEPTH = 16;
	// status flag bit positions
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;
	localparam int FLAG_I = 7;
	localparam logic [7:0] SREG_RESET = 8'h00;
	// cycle counts per instruction class
	localparam logic [1:0] CYC_ONE = 2'd1;
	localparam logic [1:0] CYC_TWO = 2'd2;
	localparam logic [1:0] CYC_THREE = 2'd3;
	localparam logic [2:0] CYC_RET = 3'd4;
	// operation codes presented by the fetch stage
	typedef enum logic [5:0] {
		OP_NOP, OP_ADD, OP_ADC, OP_SUB, OP_DIFF_CONST, OP_DIFF_BORROW,
		OP_CONST_DIFF_BORROW, OP_AND, OP_AND_CONST, OP_OR, OP_OR_CONST,
		OP_XOR, OP_INVERT, OP_TWOS, OP_SET_MASK, OP_CHECK, OP_CLEAR,
		OP_SET_ALL, OP_WORD_ADD, OP_WORD_SUB, OP_REL_JUMP, OP_PTR_JUMP,
		OP_REL_CALL, OP_PTR_CALL, OP_SUB_EXIT, OP_INT_EXIT, OP_CMP_SKIP,
		OP_CMP, OP_CMP_CARRY, OP_CMP_CONST, OP_IO_SET, OP_IO_CLEAR,
		OP_SKIP_IO_HIGH, OP_SKIP_IO_LOW
	} op_t;
endpackage

// ===== tb/mcu_arith_branch_execute_bench.sv
// self-checking bench for the arithmetic and branch execute slice
`timescale 1ns/1ps
module mcu_arith_branch_execute_bench;
	import exec_pkg::*;
	// instruction inputs, all given a value at time zero
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic instr_valid = 1'b0;
	op_t instr_op = OP_NOP;
	logic [7:0] opnd_a = 8'h00;
	logic [7:0] opnd_b = 8'h00;
	logic [7:0] opnd_k = 8'h00;
	logic [2:0] bit_sel = 3'h0;
	logic [7:0] io_addr = 8'h00;
	logic [11:0] rel_offset = 12'h000;
	logic [15:0] z_ptr = 16'h0000;
	logic next_is_long = 1'b0;
	logic [7:0] io_rdata = 8'h00;
	// design outputs
	logic busy, rf_we, rf_wide, io_bit_we, io_bit_val;
	logic [11:0] pc;
	logic [7:0] sreg, io_bit_addr, s0;
	logic [15:0] rf_wdata;
	logic [2:0] io_bit_num;
	// strobes caught in the cycle after the taking edge, and counters
	logic we_s, iow_s;
	int cyc;
	int num_errors = 0;
	int comparisons = 0;

	// 125 MHz core clock
	always #4 mclk = ~mclk;

	exec_core exec_core_inst (.mclk(mclk), .reset_n(reset_n),
		.instr_valid(instr_valid), .instr_op(instr_op), .opnd_a(opnd_a),
		.opnd_b(opnd_b), .opnd_k(opnd_k), .bit_sel(bit_sel),
		.io_addr(io_addr), .rel_offset(rel_offset), .z_ptr(z_ptr),
		.next_is_long(next_is_long), .io_rdata(io_rdata), .busy(busy),
		.pc(pc), .sreg(sreg), .rf_we(rf_we), .rf_wide(rf_wide),
		.rf_wdata(rf_wdata), .io_bit_we(io_bit_we),
		.io_bit_addr(io_bit_addr), .io_bit_num(io_bit_num),
		.io_bit_val(io_bit_val));

	// single exit point: counts, then verdict
	task automatic complete_run();
		$display("counts: %0d mismatches, %0d comparisons", num_errors,
			comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// value compare, case equality so unknowns never match
	task automatic ck(input string nm, input logic [15:0] e, g);
		comparisons++;
		if (e !== g) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	// flag compare over the bits the operation owns
	task automatic ckf(input logic [7:0] m, e);
		ck("sreg", {8'h00, e & m}, {8'h00, sreg & m});
	endtask

	// offer one instruction, then count cycles until busy drops
	task automatic run(input op_t o, input logic [7:0] x, y, k);
		int n;
		@(posedge mclk);
		#1;
		instr_valid = 1'b1;
		instr_op = o;
		opnd_a = x;
		opnd_b = y;
		opnd_k = k;
		@(posedge mclk);
		#1;
		instr_valid = 1'b0;
		we_s = rf_we;
		iow_s = io_bit_we;
		cyc = 1;
		n = 0;
		// bounded: a stuck busy ends the run as a failure
		while (busy !== 1'b0 && n < 10) begin
			@(posedge mclk);
			#1;
			cyc++;
			n++;
		end
		if (busy !== 1'b0) begin
			ck("busy_timeout", 16'h0000, {15'h0, busy});
			complete_run();
		end
	endtask

	// byte operation storing a result in one cycle
	task automatic alu(input op_t o, input logic [7:0] x, y, k, d, m, f);
		run(o, x, y, k);
		ck("rf_we", 16'h0001, {15'h0, we_s});
		ck("rf_wdata", {8'h00, d}, {8'h00, rf_wdata[7:0]});
		ckf(m, f);
		ck("cycles", 16'h0001, 16'(cyc));
	endtask

	// compare: flags only, nothing written back
	task automatic cmpf(input op_t o, input logic [7:0] x, y, k, f);
		run(o, x, y, k);
		ck("rf_we", 16'h0000, {15'h0, we_s});
		ckf(8'h2F, f);
		ck("cycles", 16'h0001, 16'(cyc));
	endtask

	// word immediate on a register pair
	task automatic wd(input op_t o, input logic [7:0] x, k,
		input logic [15:0] d, input logic [7:0] f);
		run(o, x, 8'h00, k);
		ck("rf_wide", 16'h0001, {15'h0, rf_wide});
		ck("rf_wdata", d, rf_wdata);
		ckf(8'h1F, f);
		ck("cycles", 16'h0002, 16'(cyc));
	endtask

	// flow change: new pc and cycle count
	task automatic br(input op_t o, input logic [7:0] x, y,
		input logic [11:0] p, input int c);
		run(o, x, y, 8'h00);
		ck("pc", {4'h0, p}, {4'h0, pc});
		ck("cycles", 16'(c), 16'(cyc));
	endtask

	// single io bit write, refused above the low range
	task automatic io(input op_t o, input logic [7:0] ad,
		input logic [2:0] b, input logic v, w);
		io_addr = ad;
		bit_sel = b;
		run(o, 8'h00, 8'h00, 8'h00);
		ck("io_bit_we", {15'h0, w}, {15'h0, iow_s});
		ck("rf_we", 16'h0000, {15'h0, we_s});
		ck("cycles", 16'h0002, 16'(cyc));
		if (w) begin
			ck("io_bit_addr", {8'h00, ad}, {8'h00, io_bit_addr});
			ck("io_bit_num", {13'h0, b}, {13'h0, io_bit_num});
			ck("io_bit_val", {15'h0, v}, {15'h0, io_bit_val});
		end
	endtask

	// main sequence
	initial begin
		repeat (12) @(posedge mclk);
		#1;
		ck("pc", 16'h0000, {4'h0, pc});
		ck("sreg", 16'h0000, {8'h00, sreg});
		ck("busy", 16'h0000, {15'h0, busy});
		reset_n = 1'b1;
		alu(OP_ADD, 8'h0F, 8'h01, 8'h00, 8'h10, 8'h2F, 8'h20);
		alu(OP_ADD, 8'hFF, 8'h01, 8'h00, 8'h00, 8'h2F, 8'h23);
		alu(OP_ADC, 8'h01, 8'h01, 8'h00, 8'h03, 8'h2F, 8'h00);
		alu(OP_SUB, 8'h00, 8'h01, 8'h00, 8'hFF, 8'h2F, 8'h25);
		alu(OP_CONST_DIFF_BORROW, 8'h05, 8'h00, 8'h02, 8'h02, 8'h2F,
			8'h00);
		alu(OP_DIFF_CONST, 8'h80, 8'h00, 8'h01, 8'h7F, 8'h2F, 8'h28);
		alu(OP_DIFF_BORROW, 8'h10, 8'h01, 8'h00, 8'h0F, 8'h2F, 8'h20);
		alu(OP_AND, 8'hA5, 8'h0F, 8'h00, 8'h05, 8'h0E, 8'h00);
		alu(OP_AND_CONST, 8'hA5, 8'h00, 8'hF0, 8'hA0, 8'h0E, 8'h04);
		alu(OP_OR, 8'hA5, 8'h0F, 8'h00, 8'hAF, 8'h0E, 8'h04);
		alu(OP_OR_CONST, 8'h05, 8'h00, 8'h0A, 8'h0F, 8'h0E, 8'h00);
		alu(OP_XOR, 8'hA5, 8'h0F, 8'h00, 8'hAA, 8'h0E, 8'h04);
		alu(OP_SET_MASK, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0E, 8'h02);
		cmpf(OP_CHECK, 8'h80, 8'h00, 8'h00, 8'h24);
		ckf(8'h21, 8'h20);
		alu(OP_CLEAR, 8'hA5, 8'h00, 8'h00, 8'h00, 8'h0E, 8'h02);
		alu(OP_INVERT, 8'hA5, 8'h00, 8'h00, 8'h5A, 8'h0F, 8'h01);
		alu(OP_TWOS, 8'hA5, 8'h00, 8'h00, 8'h5B, 8'h2F, 8'h21);
		s0 = sreg;
		alu(OP_SET_ALL, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, s0);
		cmpf(OP_CMP, 8'h10, 8'h20, 8'h00, 8'h05);
		cmpf(OP_CMP_CARRY, 8'h05, 8'h03, 8'h00, 8'h00);
		cmpf(OP_CMP_CONST, 8'h40, 8'h00, 8'h41, 8'h25);
		wd(OP_WORD_ADD, 8'hFF, 8'h01, 16'h0100, 8'h00);
		wd(OP_WORD_SUB, 8'h00, 8'h01, 16'hFFFF, 8'h15);
		z_ptr = 16'h0123;
		s0 = sreg;
		br(OP_PTR_JUMP, 8'h00, 8'h00, 12'h123, 2);
		ck("sreg", {8'h00, s0}, {8'h00, sreg});
		z_ptr = 16'h0456;
		br(OP_PTR_CALL, 8'h00, 8'h00, 12'h456, 3);
		br(OP_SUB_EXIT, 8'h00, 8'h00, 12'h124, 4);
		rel_offset = 12'h010;
		br(OP_REL_JUMP, 8'h00, 8'h00, 12'h135, 2);
		rel_offset = 12'hFFE;
		br(OP_REL_CALL, 8'h00, 8'h00, 12'h134, 3);
		br(OP_INT_EXIT, 8'h00, 8'h00, 12'h136, 4);
		ck("sreg_i", 16'h0001, {15'h0, sreg[FLAG_I]});
		br(OP_CMP_SKIP, 8'h01, 8'h02, 12'h137, 1);
		br(OP_CMP_SKIP, 8'h05, 8'h05, 12'h139, 2);
		next_is_long = 1'b1;
		br(OP_CMP_SKIP, 8'h05, 8'h05, 12'h13C, 3);
		next_is_long = 1'b0;
		io_rdata = 8'h80; // reserved bits kept at zero
		bit_sel = 3'h7;
		io_addr = 8'h1F;
		br(OP_SKIP_IO_HIGH, 8'h00, 8'h00, 12'h13E, 2);
		br(OP_SKIP_IO_LOW, 8'h00, 8'h00, 12'h13F, 1);
		io_addr = 8'h20;
		br(OP_SKIP_IO_HIGH, 8'h00, 8'h00, 12'h140, 1);
		io(OP_IO_SET, 8'h1F, 3'h7, 1'b1, 1'b1);
		io(OP_IO_CLEAR, 8'h00, 3'h0, 1'b0, 1'b1);
		io(OP_IO_SET, 8'h20, 3'h3, 1'b1, 1'b0);
		complete_run();
	end
endmodule
